// ---- hdl/status_word_defs.vh ----
`ifndef STATUS_WORD_DEFS_VH
`define STATUS_WORD_DEFS_VH
// ****************************************
// Register map (word byte addresses)
// ****************************************
`define ADR_STATUS_WORD 4'h0
`define ADR_STRIDE_ZERO 4'h4
`define ADR_STRIDE_ONE 4'h8
`define ADR_PRIV_FLAGS 4'hC
// ****************************************
// Status word bit positions
// ****************************************
`define B_ADDR_CARRY 31
`define B_ADDR_DZ 29
`define B_DATA_CARRY 23
`define B_SCALAR_DZ 21
`define B_DZ_TE 20
`define B_TINY 19
`define B_LARGE 18
`define B_BADOP 17
`define B_FDZ 16
`define B_FP_TE 15
`define B_TINY_TE 14
`define B_IEEE 13
`define B_ORDERED 12
`define B_INTR_ERR 11
`define B_INTR_TE 10
`define B_TTC 9
`define B_TIT 8
`define B_CC3 7
`define B_CC2 6
`define B_CAT 4
`define B_IEC_HI 3
`define B_IEC_LO 0
// Bits that software may write directly
`define SW_WR_MASK 32'hFFFF_FFDF
`define PSW_RESET 32'h0000_0000
`define ZERO32 32'h0000_0000
// ****************************************
// Intrinsic error codes
// ****************************************
`define IEC_SQRT_NEG 4'h0
`define IEC_EXP_OVF 4'h1
`define IEC_LOG_NPOS 4'h2
`define IEC_SIN_BIG 4'h6
`define IEC_COS_BIG 4'h7
// ****************************************
// Trap causes and misc
// ****************************************
`define CAUSE_NONE 3'h0
`define CAUSE_DZ 3'h1
`define CAUSE_FP 3'h2
`define CAUSE_TINY 3'h3
`define CAUSE_INTR 3'h4
`define FORK_TRACE_CODE 32'h0000_0800
`define RING_TOP 3'h0
`endif

// ---- hdl/stride_regs.v ----
`timescale 1ns/1ps
`include "status_word_defs.vh"
module stride_regs (
   input wire clk_i,
   input wire rst_i,
   input wire we_i,
   input wire wsel_i,
   input wire [31:0] wdata_i,
   input wire rsel_i,
   output reg [31:0] rdata_o,
   input wire [31:0] effa_i,
   output reg [31:0] pf_addr_zero_o,
   output reg [31:0] pf_addr_one_o
);
   reg [31:0] stride_r [0:1];
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : slot
         always @(posedge clk_i) begin
            if (rst_i) begin
               stride_r[g] <= `ZERO32;
            end else if (we_i && (wsel_i == g)) begin
               stride_r[g] <= wdata_i;
            end
         end
      end
   endgenerate
   always @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= `ZERO32;
         pf_addr_zero_o <= `ZERO32;
         pf_addr_one_o <= `ZERO32;
      end else begin
         rdata_o <= stride_r[rsel_i];
         pf_addr_zero_o <= effa_i + stride_r[0];
         pf_addr_one_o <= effa_i + stride_r[1];
      end
   end
endmodule

// ---- hdl/status_word_trap_flags.v ----
// Contract
// - Divide-zero enable with integer divzero flag traps
// - Underflow sets sticky flag until cleared
// - Overflow sets sticky flag until cleared
// - Bad operand sets sticky flag
// - Float divide by zero sets sticky flag
// - Float enable with float flags traps
// - Underflow enable with underflow flag traps
// - Underflow always yields exact zero result
// - Format bit selects IEEE or native arithmetic
// - Ordered-store bit forces in-order store commit
// - Intrinsic error sets flag and code
// - Intrinsic enable with flag traps
// - Concurrency trace traps around idle state
// - Fork setup bit gives trace trap, code
// - Extended compares write, branches test condition bits
// - Bad comm address sets sticky flag, violation
// - Comm flag cleared in handler frame copy
// - New intrinsic error replaces old code
// - Intrinsic error code encodings fixed
// - Stride loads prefetch effective address plus stride
// - Enable/disable instructions set/clear interrupt flag
// - Vector-saved load only in top ring
// - Vector-saved test copies flag to carry
// - Scalar carry at bit 23 from arithmetic
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "status_word_defs.vh"
module status_word_trap_flags (
   input wire clk_i,
   input wire rst_i,
   // Classic Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // Execution unit events, one instruction per retire pulse
   input wire retire_i,
   input wire ev_tiny_i,
   input wire ev_large_i,
   input wire ev_badop_i,
   input wire ev_fdz_i,
   input wire ev_sdz_i,
   input wire ev_adz_i,
   input wire ev_intr_err_i,
   input wire [3:0] ev_intr_code_i,
   input wire ev_data_carry_we_i,
   input wire ev_data_carry_i,
   input wire ev_cc_we_i,
   input wire ev_cc3_i,
   input wire ev_cc2_i,
   input wire ev_comm_bad_i,
   input wire idle_enter_i,
   input wire idle_leave_i,
   input wire fork_accept_i,
   input wire fork_setup_bit_i,
   input wire irq_enable_op_i,
   input wire irq_disable_op_i,
   input wire vsaved_load_i,
   input wire vsaved_src_i,
   input wire [2:0] ring_i,
   input wire vsaved_test_i,
   input wire trap_ack_i,
   input wire [31:0] effa_i,
   // Outputs to units and trap sequencer
   output reg [31:0] status_word_o,
   output reg ieee_mode_o,
   output reg ordered_store_o,
   output reg force_zero_o,
   output reg cc3_o,
   output reg cc2_o,
   output reg arith_trap_o,
   output reg [2:0] arith_cause_o,
   output reg trace_trap_o,
   output reg fork_trap_o,
   output reg [31:0] fork_code_o,
   output reg ring_violation_o,
   output reg [31:0] frame_word_o,
   output reg external_irq_enable_o,
   output reg vector_saved_flag_o,
   output reg [31:0] pf_addr_zero_o,
   output reg [31:0] pf_addr_one_o
);
   // ****************************************
   // Status word and privileged flags
   // ****************************************
   reg [31:0] psw_r;
   reg [31:0] psw_nxt;
   reg irq_en_r;
   reg vsaved_r;
   reg [31:0] wmask;
   wire bus_req = cyc_i && stb_i && !ack_o;
   wire psw_wr = bus_req && we_i && (adr_i == `ADR_STATUS_WORD);
   integer k;
   always @* begin
      for (k = 0; k < 4; k = k + 1) begin
         wmask[k*8 +: 8] = {8{sel_i[k]}};
      end
   end
   always @* begin
      psw_nxt = psw_r;
      // Software write first so hardware events win over a clear
      if (psw_wr) begin
         psw_nxt = (psw_r & ~(wmask & `SW_WR_MASK)) | (dat_i & wmask & `SW_WR_MASK);
      end
      if (retire_i) begin
         if (ev_tiny_i) psw_nxt[`B_TINY] = 1'b1;
         if (ev_large_i) psw_nxt[`B_LARGE] = 1'b1;
         if (ev_badop_i) psw_nxt[`B_BADOP] = 1'b1;
         if (ev_fdz_i) psw_nxt[`B_FDZ] = 1'b1;
         if (ev_sdz_i) psw_nxt[`B_SCALAR_DZ] = 1'b1;
         if (ev_adz_i) psw_nxt[`B_ADDR_DZ] = 1'b1;
         if (ev_intr_err_i) begin
            // Old code dropped, latest error kept
            psw_nxt[`B_IEC_HI:`B_IEC_LO] = ev_intr_code_i;
            psw_nxt[`B_INTR_ERR] = 1'b1;
         end
         if (ev_data_carry_we_i) psw_nxt[`B_DATA_CARRY] = ev_data_carry_i;
         if (ev_cc_we_i) begin
            psw_nxt[`B_CC3] = ev_cc3_i;
            psw_nxt[`B_CC2] = ev_cc2_i;
         end
         if (vsaved_test_i) psw_nxt[`B_DATA_CARRY] = vsaved_r;
      end
      // Sticky until the sequencer recognizes the trap
      if (trap_ack_i && psw_r[`B_CAT]) psw_nxt[`B_CAT] = 1'b0;
      if (ev_comm_bad_i) psw_nxt[`B_CAT] = 1'b1;
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         psw_r <= `PSW_RESET;
         irq_en_r <= 1'b0;
         vsaved_r <= 1'b0;
      end else begin
         psw_r <= psw_nxt;
         if (irq_enable_op_i) begin
            irq_en_r <= 1'b1;
         end else if (irq_disable_op_i) begin
            irq_en_r <= 1'b0;
         end
         // Outer rings see a no-op
         if (vsaved_load_i && ring_i == `RING_TOP) begin
            vsaved_r <= vsaved_src_i;
         end
      end
   end
   // ****************************************
   // Trap evaluation after flag update
   // ****************************************
   reg [2:0] cause;
   always @* begin
      cause = `CAUSE_NONE;
      // Fixed priority: one request per instruction
      if (psw_nxt[`B_INTR_TE] && psw_nxt[`B_INTR_ERR]) begin
         cause = `CAUSE_INTR;
      end else if (psw_nxt[`B_FP_TE] && (psw_nxt[`B_LARGE] | psw_nxt[`B_BADOP] | psw_nxt[`B_FDZ])) begin
         cause = `CAUSE_FP;
      end else if (psw_nxt[`B_TINY_TE] && psw_nxt[`B_TINY]) begin
         cause = `CAUSE_TINY;
      end else if (psw_nxt[`B_DZ_TE] && (psw_nxt[`B_SCALAR_DZ] | psw_nxt[`B_ADDR_DZ])) begin
         cause = `CAUSE_DZ;
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         arith_trap_o <= 1'b0;
         arith_cause_o <= `CAUSE_NONE;
         trace_trap_o <= 1'b0;
         fork_trap_o <= 1'b0;
         fork_code_o <= `ZERO32;
         ring_violation_o <= 1'b0;
         frame_word_o <= `ZERO32;
         force_zero_o <= 1'b0;
      end else begin
         // Pulses once per retired instruction only
         arith_trap_o <= retire_i && (cause != `CAUSE_NONE);
         arith_cause_o <= retire_i ? cause : `CAUSE_NONE;
         trace_trap_o <= psw_r[`B_TTC] && (idle_enter_i || idle_leave_i);
         fork_trap_o <= fork_accept_i && fork_setup_bit_i;
         fork_code_o <= (fork_accept_i && fork_setup_bit_i) ? `FORK_TRACE_CODE : `ZERO32;
         ring_violation_o <= ev_comm_bad_i;
         frame_word_o <= psw_r & ~(32'h0000_0001 << `B_CAT);
         force_zero_o <= retire_i && ev_tiny_i;
      end
   end
   // ****************************************
   // Mode bit outputs
   // ****************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         status_word_o <= `PSW_RESET;
         ieee_mode_o <= 1'b0;
         ordered_store_o <= 1'b0;
         cc3_o <= 1'b0;
         cc2_o <= 1'b0;
         external_irq_enable_o <= 1'b0;
         vector_saved_flag_o <= 1'b0;
      end else begin
         status_word_o <= psw_nxt;
         ieee_mode_o <= psw_nxt[`B_IEEE];
         ordered_store_o <= psw_nxt[`B_ORDERED];
         cc3_o <= psw_nxt[`B_CC3];
         cc2_o <= psw_nxt[`B_CC2];
         external_irq_enable_o <= irq_en_r;
         vector_saved_flag_o <= vsaved_r;
      end
   end
   // ****************************************
   // Stride registers and bus slave
   // ****************************************
   wire stride_hit = (adr_i == `ADR_STRIDE_ZERO) || (adr_i == `ADR_STRIDE_ONE);
   wire stride_one = (adr_i == `ADR_STRIDE_ONE);
   wire [31:0] stride_rdata;
   wire [31:0] pf0;
   wire [31:0] pf1;
   stride_regs u_stride (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(bus_req && we_i && stride_hit && (sel_i == 4'hF)),
      .wsel_i(stride_one),
      .wdata_i(dat_i),
      .rsel_i(stride_one),
      .rdata_o(stride_rdata),
      .effa_i(effa_i),
      .pf_addr_zero_o(pf0),
      .pf_addr_one_o(pf1)
   );
   // Stride read data is registered, so ack comes two cycles after request
   reg pend_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         pend_r <= 1'b0;
         ack_o <= 1'b0;
         dat_o <= `ZERO32;
         pf_addr_zero_o <= `ZERO32;
         pf_addr_one_o <= `ZERO32;
      end else begin
         pf_addr_zero_o <= pf0;
         pf_addr_one_o <= pf1;
         ack_o <= 1'b0;
         pend_r <= 1'b0;
         if (bus_req && !pend_r) begin
            pend_r <= 1'b1;
         end else if (bus_req && pend_r) begin
            ack_o <= 1'b1;
            case (adr_i)
               `ADR_STATUS_WORD: dat_o <= psw_r;
               `ADR_STRIDE_ZERO: dat_o <= stride_rdata;
               `ADR_STRIDE_ONE: dat_o <= stride_rdata;
               `ADR_PRIV_FLAGS: dat_o <= {30'h0000_0000, vsaved_r, irq_en_r};
               default: dat_o <= `ZERO32;
            endcase
         end
      end
   end
endmodule

// ---- testbench/status_word_trap_flags_assertions.sv ----
`timescale 1ns/1ps
module status_word_trap_flags_assertions (
   input logic clk_i,
   input logic rst_i,
   input logic cyc_i,
   input logic stb_i,
   input logic we_i,
   input logic ack_o,
   input logic retire_i,
   input logic ev_tiny_i,
   input logic ev_sdz_i,
   input logic ev_adz_i,
   input logic ev_comm_bad_i,
   input logic irq_enable_op_i,
   input logic [31:0] status_word_o,
   input logic arith_trap_o,
   input logic ring_violation_o,
   input logic [31:0] frame_word_o,
   input logic external_irq_enable_o
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Enable sampled before the event lands
   sequence s_dz_event;
      retire_i && (ev_sdz_i || ev_adz_i) && status_word_o[20];
   endsequence
   sequence s_req_start;
      $rose(cyc_i && stb_i);
   endsequence
   a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   a_ack_delay: assert property (s_req_start |=> !ack_o ##1 ack_o) else $error("ack not on second edge");
   a_tiny_sets: assert property (retire_i && ev_tiny_i |=> status_word_o[19])
      else $error("underflow flag not set");
   a_large_holds: assert property (status_word_o[18] && !(cyc_i && stb_i && we_i) |=> status_word_o[18])
      else $error("overflow flag lost");
   a_dz_traps: assert property (s_dz_event |-> ##[1:2] arith_trap_o)
      else $error("divide trap missing");
   a_trap_per_retire: assert property (arith_trap_o |-> $past(retire_i))
      else $error("trap without retire");
   a_comm_violation: assert property (ev_comm_bad_i |-> ##[1:2] (ring_violation_o && status_word_o[4]))
      else $error("comm address fault lost");
   a_frame_clear: assert property (frame_word_o[4] == 1'b0)
      else $error("frame keeps comm flag");
   a_irq_on: assert property (irq_enable_op_i |-> ##[1:2] external_irq_enable_o)
      else $error("irq enable not set");
endmodule
bind status_word_trap_flags status_word_trap_flags_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
   .ack_o, .retire_i, .ev_tiny_i, .ev_sdz_i, .ev_adz_i, .ev_comm_bad_i, .irq_enable_op_i, .status_word_o,
   .arith_trap_o, .ring_violation_o, .frame_word_o, .external_irq_enable_o);

// ---- testbench/status_word_trap_flags_bench.sv ----
`timescale 1ns/1ps
module status_word_trap_flags_bench;
   // ****************
   // Stimulus
   // ****************
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, retire_i = 0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'hF, code = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000, effa_i = 32'h0000_0000, rd;
   logic [22:0] ev = 23'h00_0000;
   logic [2:0] ring_i = 3'h0;
   wire [31:0] dat_o, status_word_o, frame_word_o, pf_addr_zero_o, pf_addr_one_o;
   wire [2:0] arith_cause_o;
   wire ack_o, ieee_mode_o, ordered_store_o, cc3_o, cc2_o, arith_trap_o, ring_violation_o;
   wire external_irq_enable_o, vector_saved_flag_o, force_zero_o, trace_trap_o, fork_trap_o;
   wire [31:0] fork_code_o;
   int miscompares = 0, compares = 0;
   always #25 clk_i = ~clk_i;
   status_word_trap_flags u_status_word_trap_flags (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .retire_i, .ev_tiny_i(ev[0]), .ev_large_i(ev[1]), .ev_badop_i(ev[2]),
      .ev_fdz_i(ev[3]), .ev_sdz_i(ev[4]), .ev_adz_i(ev[5]), .ev_intr_err_i(ev[6]), .ev_intr_code_i(code),
      .ev_data_carry_we_i(ev[7]), .ev_data_carry_i(ev[8]), .ev_cc_we_i(ev[9]), .ev_cc3_i(ev[10]),
      .ev_cc2_i(ev[11]), .ev_comm_bad_i(ev[12]), .idle_enter_i(ev[13]), .idle_leave_i(ev[14]),
      .fork_accept_i(ev[15]), .fork_setup_bit_i(ev[16]), .irq_enable_op_i(ev[17]), .irq_disable_op_i(ev[18]),
      .vsaved_load_i(ev[19]), .vsaved_src_i(ev[20]), .vsaved_test_i(ev[21]), .trap_ack_i(ev[22]), .ring_i,
      .effa_i, .status_word_o, .ieee_mode_o, .ordered_store_o, .force_zero_o, .cc3_o, .cc2_o, .arith_trap_o,
      .arith_cause_o, .trace_trap_o, .fork_trap_o, .fork_code_o, .ring_violation_o, .frame_word_o,
      .external_irq_enable_o, .vector_saved_flag_o, .pf_addr_zero_o, .pf_addr_one_o);
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits for ack with a bound; a missing ack counts as a mismatch
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      if (n >= 20) miscompares++;
      cyc_i <= 0;
      stb_i <= 0;
   endtask
   task ret(input logic [22:0] v, input logic [3:0] c = 4'h0, input logic [2:0] r = 3'h0);
      @(posedge clk_i);
      retire_i <= 1;
      ev <= v;
      code <= c;
      ring_i <= r;
      @(posedge clk_i);
      retire_i <= 0;
      ev <= 23'h00_0000;
      #1;
   endtask
   task t_regs;
      chk(status_word_o, 32'h0000_0000, "reset psw");
      wb(1, 4'h0, 32'h0000_30C0);
      @(posedge clk_i);
      #1;
      chk({ieee_mode_o, ordered_store_o, cc3_o, cc2_o}, 4'hF, "mode bits");
      wb(0, 4'h0, 32'h0000_0000);
      chk(rd, 32'h0000_30C0, "psw read");
      wb(0, 4'h2, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped read");
      $display("regs test done");
   endtask
   task t_traps;
      logic [31:0] en[3] = '{32'h0010_0000, 32'h0000_8000, 32'h0000_4000};
      logic [22:0] evt[3] = '{23'h00_0010, 23'h00_0002, 23'h00_0001};
      wb(1, 4'h0, 32'h0000_0000);
      ret(23'h00_000F);
      chk(status_word_o[19:16], 4'hF, "flags set");
      chk(arith_trap_o, 1'b0, "trap disabled");
      ret(23'h00_0000);
      chk(status_word_o[19:16], 4'hF, "flags hold");
      for (int i = 0; i < 3; i++) begin
         wb(1, 4'h0, en[i]);
         ret(evt[i]);
         chk({arith_trap_o, arith_cause_o}, {1'b1, 3'(i + 1)}, "trap cause");
      end
      $display("trap test done");
   endtask
   task t_intr;
      logic [3:0] codes[5] = '{4'h7, 4'h6, 4'h2, 4'h1, 4'h0};
      wb(1, 4'h0, 32'h0000_0000);
      foreach (codes[i]) begin
         ret(23'h00_0040, codes[i]);
         chk({status_word_o[11], status_word_o[3:0]}, {1'b1, codes[i]}, "intr code");
      end
      wb(1, 4'h0, 32'h0000_0400);
      ret(23'h00_0040, 4'h1);
      chk({arith_trap_o, arith_cause_o}, 4'hC, "intr trap");
      $display("intrinsic test done");
   endtask
   task t_trace;
      wb(1, 4'h0, 32'h0000_0200);
      ret(23'h00_2000);
      chk(trace_trap_o, 1'b1, "idle trace");
      ret(23'h01_8000);
      chk({fork_trap_o, fork_code_o}, 33'h1_0000_0800, "fork trace");
      ret(23'h00_0001);
      chk(force_zero_o, 1'b1, "true zero");
      $display("trace test done");
   endtask
   task t_comm;
      ret(23'h00_1000);
      chk({ring_violation_o, status_word_o[4], frame_word_o[4]}, 3'h6, "comm fault");
      ret(23'h40_0000);
      chk(status_word_o[4], 1'b0, "comm ack");
      $display("comm test done");
   endtask
   task t_priv;
      ret(23'h02_0000);
      ret(23'h18_0000, 4'h0, 3'h4);
      @(posedge clk_i);
      #1;
      chk({external_irq_enable_o, vector_saved_flag_o}, 2'h2, "low ring load");
      ret(23'h18_0000);
      ret(23'h20_0000);
      chk(status_word_o[23], 1'b1, "vsaved test");
      wb(0, 4'hC, 32'h0000_0000);
      chk(rd[1:0], 2'h3, "priv read");
      ret(23'h04_0000);
      @(posedge clk_i);
      #1;
      chk(external_irq_enable_o, 1'b0, "irq off");
      $display("priv test done");
   endtask
   task t_stride;
      wb(1, 4'h4, 32'h0000_0010);
      wb(1, 4'h8, 32'h0000_0100);
      effa_i <= 32'h0000_1000;
      repeat (3) @(posedge clk_i);
      #1;
      chk(pf_addr_zero_o, 32'h0000_1010, "prefetch zero");
      chk(pf_addr_one_o, 32'h0000_1100, "prefetch one");
      $display("stride test done");
   endtask
   task conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      t_regs;
      t_traps;
      t_intr;
      t_trace;
      t_comm;
      t_priv;
      t_stride;
      conclude;
   end
   // Run needs about 110 cycles
   initial begin
      #150_000;
      miscompares++;
      conclude;
   end
endmodule
